// >>> design/char_tick_divider.sv
// Purpose: one-cycle enable every DIV clocks (character clock)
// Assumes: free running from reset
// Notes:   tick_o is a flop output

`timescale 1ns/1ps
`default_nettype none

module char_tick_divider #(
  parameter int DIV = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [$clog2(DIV)-1:0] cnt_q;

  // modulo counter, pulse on last count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q == ($clog2(DIV))'(DIV - 1));
      if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  chk_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o [*7] ##1 tick_o)
    else $error("character tick not every 8 clocks");
endmodule

`default_nettype wire

// >>> design/lcd_vr_pkg.sv
// Purpose: shared constants for the virtual refresh panel timing block
// Assumes: indexed byte-wide I/O port pair, one 10 MHz clock
// Notes:   index and data ports, register indexes, field positions

package lcd_vr_pkg;
  // I/O port pair: index latch and data window
  localparam logic [15:0] IDX_PORT  = 16'h03C4;
  localparam logic [15:0] DATA_PORT = 16'h03C5;

  // register indexes
  localparam logic [7:0] IDX_OVF1 = 8'h50;
  localparam logic [7:0] IDX_OVF2 = 8'h51;
  localparam logic [7:0] IDX_HT   = 8'h52;
  localparam logic [7:0] IDX_HDE  = 8'h53;
  localparam logic [7:0] IDX_HSS  = 8'h54;
  localparam logic [7:0] IDX_VT   = 8'h55;
  localparam logic [7:0] IDX_VDE  = 8'h56;
  localparam logic [7:0] IDX_VSS  = 8'h57;
  localparam logic [7:0] IDX_EMI  = 8'h58;
  localparam logic [7:0] IDX_MOD  = 8'h59;

  // reset values; timing registers have none defined, cleared here
  localparam logic [7:0] EMI_RST    = 8'h00;
  localparam logic [7:0] MOD_RST    = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;

  // field positions
  localparam int OVF1_HSS8   = 0;
  localparam int OVF1_VT_LO  = 1;
  localparam int OVF2_HT8    = 0;
  localparam int OVF2_HDE8   = 1;
  localparam int OVF2_VDE_LO = 2;
  localparam int OVF2_VSS_LO = 5;
  localparam int EMI_DLY_LO  = 0;
  localparam int EMI_PAD     = 2;
  localparam int EMI_RED     = 3;
  localparam int MOD_SEL     = 7;
  localparam logic [7:0] OVF1_MASK = 8'h0F;
  localparam logic [7:0] EMI_MASK  = 8'h0F;

  // panel geometry and timing counts
  localparam int          CHAR_PIXELS = 8;
  localparam logic [1:0]  PANEL_DSTN  = 2'b01;
  localparam logic [9:0]  HS_NARROW   = 10'h001;
  localparam logic [9:0]  HS_WIDE     = 10'h002;
endpackage

// >>> design/lcd_vr_timing.sv
// Purpose: virtual refresh panel timing, EMI and modulation control
// Assumes: clk_i is the pixel clock; host uses the indexed I/O pair
// Notes:   panel type, refresh enable and sync width come as inputs
//
// Summary of operation
// - horizontal total counts 8-pixel characters
// - horizontal total ninth bit from overflow two
// - display end 9 bits, bit 8 overflow two
// - line sync starts at sync start value
// - sync start bit 8 from overflow one
// - line sync 8 or 16 pixels wide
// - vertical total 11 bits, overflow one 3:1
// - dstn programs half height lines
// - vertical display end high bits overflow two
// - vertical sync start high bits overflow two
// - frame sync lasts one line
// - timing runs only in virtual refresh
// - emi bit 3 enables reduction
// - emi bit 2 picks pad drive
// - emi bits 1:0 delay shift clock
// - modulation bit 7 picks line/frame clock
// - modulation count sets modulation rate
// - emi and modulation reset to zero
// - refresh enable bit; dstn type 01

`timescale 1ns/1ps
`default_nettype none

module lcd_vr_timing #(
  parameter int HW = 9,
  parameter int VW = 11
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  input  wire logic        vr_enable_i,
  input  wire logic [1:0]  panel_type_i,
  input  wire logic        hsync_wide_i,
  output logic             hsync_o,
  output logic             vsync_o,
  output logic             line_pulse_o,
  output logic             frame_pulse_o,
  output logic             display_enable_o,
  output logic             panel_shift_clock_o,
  output logic             emi_reduction_enable_o,
  output logic             pad_drive_6ma_o,
  output logic             modulation_o
);
  logic [7:0]    index_q;
  logic [7:0]    ovf1_q;
  logic [7:0]    ovf2_q;
  logic [7:0]    ht_q;
  logic [7:0]    hde_q;
  logic [7:0]    hss_q;
  logic [7:0]    vt_q;
  logic [7:0]    vde_q;
  logic [7:0]    vss_q;
  logic [7:0]    emi_q;
  logic [7:0]    mod_q;
  logic [7:0]    rd_d;
  logic [HW-1:0] horiz_total_value;
  logic [HW-1:0] horiz_display_end_value;
  logic [HW-1:0] horiz_sync_start_value;
  logic [VW-1:0] vert_total_value;
  logic [VW-1:0] vert_display_end_value;
  logic [VW-1:0] vert_sync_start_value;
  logic [HW-1:0] h_cnt_q;
  logic [VW-1:0] v_cnt_q;
  logic          char_en;
  logic          run;
  logic          dstn;
  logic          line_end;
  logic          frame_end;
  logic          hs_win;
  logic          vs_win;
  logic          de_win;
  logic [9:0]    hs_len;
  logic [9:0]    hs_stop;
  logic          mod_tick;
  logic          sclk_q;
  logic [3:0]    sclk_dly_q;

  // host port decode
  wire idx_sel  = (io_addr_i == lcd_vr_pkg::IDX_PORT);
  wire data_sel = (io_addr_i == lcd_vr_pkg::DATA_PORT);

  // index latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_q <= 8'h00;
    end else if (io_wr_i && idx_sel) begin
      index_q <= io_wdata_i;
    end
  end

  // timing registers; undefined at power-on, cleared for determinism
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf1_q <= lcd_vr_pkg::TIMING_RST;
      ovf2_q <= lcd_vr_pkg::TIMING_RST;
      ht_q   <= lcd_vr_pkg::TIMING_RST;
      hde_q  <= lcd_vr_pkg::TIMING_RST;
      hss_q  <= lcd_vr_pkg::TIMING_RST;
      vt_q   <= lcd_vr_pkg::TIMING_RST;
      vde_q  <= lcd_vr_pkg::TIMING_RST;
      vss_q  <= lcd_vr_pkg::TIMING_RST;
    end else if (io_wr_i && data_sel) begin
      case (index_q)
        lcd_vr_pkg::IDX_OVF1: ovf1_q <= io_wdata_i & lcd_vr_pkg::OVF1_MASK;
        lcd_vr_pkg::IDX_OVF2: ovf2_q <= io_wdata_i;
        lcd_vr_pkg::IDX_HT:   ht_q   <= io_wdata_i;
        lcd_vr_pkg::IDX_HDE:  hde_q  <= io_wdata_i;
        lcd_vr_pkg::IDX_HSS:  hss_q  <= io_wdata_i;
        lcd_vr_pkg::IDX_VT:   vt_q   <= io_wdata_i;
        lcd_vr_pkg::IDX_VDE:  vde_q  <= io_wdata_i;
        lcd_vr_pkg::IDX_VSS:  vss_q  <= io_wdata_i;
        default: ;
      endcase
    end
  end

  // control registers with defined power-on value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      emi_q <= lcd_vr_pkg::EMI_RST;
      mod_q <= lcd_vr_pkg::MOD_RST;
    end else if (io_wr_i && data_sel) begin
      if (index_q == lcd_vr_pkg::IDX_EMI) begin
        emi_q <= io_wdata_i & lcd_vr_pkg::EMI_MASK;
      end
      if (index_q == lcd_vr_pkg::IDX_MOD) begin
        mod_q <= io_wdata_i;
      end
    end
  end

  // read mux; other indexes belong to other blocks and read zero
  always_comb begin
    rd_d = 8'h00;
    case (index_q)
      lcd_vr_pkg::IDX_OVF1: rd_d = ovf1_q;
      lcd_vr_pkg::IDX_OVF2: rd_d = ovf2_q;
      lcd_vr_pkg::IDX_HT:   rd_d = ht_q;
      lcd_vr_pkg::IDX_HDE:  rd_d = hde_q;
      lcd_vr_pkg::IDX_HSS:  rd_d = hss_q;
      lcd_vr_pkg::IDX_VT:   rd_d = vt_q;
      lcd_vr_pkg::IDX_VDE:  rd_d = vde_q;
      lcd_vr_pkg::IDX_VSS:  rd_d = vss_q;
      lcd_vr_pkg::IDX_EMI:  rd_d = emi_q;
      lcd_vr_pkg::IDX_MOD:  rd_d = mod_q;
      default:              rd_d = 8'h00;
    endcase
  end

  // read data registered; index port reads back the latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i && idx_sel) begin
      io_rdata_o <= index_q;
    end else if (io_rd_i && data_sel) begin
      io_rdata_o <= rd_d;
    end
  end

  // assembled timing values
  assign horiz_total_value       = {ovf2_q[lcd_vr_pkg::OVF2_HT8], ht_q};
  assign horiz_display_end_value = {ovf2_q[lcd_vr_pkg::OVF2_HDE8], hde_q};
  assign horiz_sync_start_value  = {ovf1_q[lcd_vr_pkg::OVF1_HSS8], hss_q};
  assign vert_total_value        = {ovf1_q[lcd_vr_pkg::OVF1_VT_LO +: 3], vt_q};
  assign vert_display_end_value  = {ovf2_q[lcd_vr_pkg::OVF2_VDE_LO +: 3], vde_q};
  assign vert_sync_start_value   = {ovf2_q[lcd_vr_pkg::OVF2_VSS_LO +: 3], vss_q};

  // mode decode
  assign run  = vr_enable_i;
  assign dstn = (panel_type_i == lcd_vr_pkg::PANEL_DSTN);

  // character clock enable, one pulse per 8 pixels
  char_tick_divider #(
    .DIV(lcd_vr_pkg::CHAR_PIXELS)
  ) u_char_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (char_en)
  );

  assign line_end  = run && char_en && (h_cnt_q == horiz_total_value);
  assign frame_end = line_end && (v_cnt_q == vert_total_value);

  // horizontal counter in characters; a dstn period is two panel lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_cnt_q <= '0;
    end else if (!run) begin
      h_cnt_q <= '0;
    end else if (char_en) begin
      if (h_cnt_q == horiz_total_value) begin
        h_cnt_q <= '0;
      end else begin
        h_cnt_q <= h_cnt_q + 1'b1;
      end
    end
  end

  // vertical counter; dstn totals already hold half the panel height
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      v_cnt_q <= '0;
    end else if (!run) begin
      v_cnt_q <= '0;
    end else if (line_end) begin
      if (v_cnt_q == vert_total_value) begin
        v_cnt_q <= '0;
      end else begin
        v_cnt_q <= v_cnt_q + 1'b1;
      end
    end
  end

  // sync windows; a start at or before the display end would overlap active video
  assign hs_len  = hsync_wide_i ? lcd_vr_pkg::HS_WIDE : lcd_vr_pkg::HS_NARROW;
  assign hs_stop = {1'b0, horiz_sync_start_value} + hs_len;
  assign hs_win  = (h_cnt_q >= horiz_sync_start_value)
                   && ({1'b0, h_cnt_q} < hs_stop);
  assign vs_win  = (v_cnt_q == vert_sync_start_value);
  assign de_win  = (h_cnt_q <= horiz_display_end_value)
                   && (v_cnt_q <= vert_display_end_value);

  // panel sync outputs, routed by panel type
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hsync_o          <= 1'b0;
      vsync_o          <= 1'b0;
      line_pulse_o     <= 1'b0;
      frame_pulse_o    <= 1'b0;
      display_enable_o <= 1'b0;
    end else begin
      hsync_o          <= run && !dstn && hs_win;
      line_pulse_o     <= run && dstn && hs_win;
      vsync_o          <= run && !dstn && vs_win;
      frame_pulse_o    <= run && dstn && vs_win;
      display_enable_o <= run && de_win;
    end
  end

  // pad controls go to the pad ring through one register stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      emi_reduction_enable_o <= 1'b0;
      pad_drive_6ma_o        <= 1'b0;
    end else begin
      emi_reduction_enable_o <= emi_q[lcd_vr_pkg::EMI_RED];
      pad_drive_6ma_o        <= emi_q[lcd_vr_pkg::EMI_PAD];
    end
  end

  // shift clock at half pixel rate; one delay unit is one clock here,
  // finer analog delay taps are not available in a single-clock design
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q              <= 1'b0;
      sclk_dly_q          <= 4'h0;
      panel_shift_clock_o <= 1'b0;
    end else begin
      sclk_q              <= run && !sclk_q;
      sclk_dly_q          <= {sclk_dly_q[2:0], sclk_q};
      panel_shift_clock_o <= sclk_dly_q[emi_q[lcd_vr_pkg::EMI_DLY_LO +: 2]];
    end
  end

  // modulation clock select: frame or line
  assign mod_tick = mod_q[lcd_vr_pkg::MOD_SEL] ? line_end : frame_end;

  panel_mod_gen #(
    .CW(7)
  ) u_mod (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (run),
    .tick_i  (mod_tick),
    .count_i (mod_q[6:0]),
    .mod_o   (modulation_o)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_hcnt_wrap: assert property (
    run && char_en && h_cnt_q == horiz_total_value |=> h_cnt_q == '0)
    else $error("horizontal counter did not wrap");

  chk_hcnt_hold: assert property (
    run && !char_en |=> h_cnt_q == $past(h_cnt_q))
    else $error("horizontal counter moved off character tick");

  chk_vcnt_step: assert property (
    line_end && v_cnt_q != vert_total_value |=> v_cnt_q == $past(v_cnt_q) + 1'b1)
    else $error("vertical counter did not step at line end");

  chk_hsync_start: assert property (
    run && $rose(h_cnt_q == horiz_sync_start_value) |=> (hsync_o || line_pulse_o))
    else $error("line sync not started at sync start");

  chk_hsync_width: assert property (
    $rose(hsync_o) && !hsync_wide_i && $stable(hss_q) |-> hsync_o [*8] ##1 !hsync_o)
    else $error("narrow line sync not 8 pixels");

  chk_vsync_line: assert property (
    run && !dstn && vs_win |=> vsync_o)
    else $error("frame sync missing on its line");

  chk_vr_off: assert property (
    !run |=> h_cnt_q == '0 && v_cnt_q == '0 && !hsync_o && !vsync_o)
    else $error("timing active outside virtual refresh");

  chk_de_end: assert property (
    run && h_cnt_q > horiz_display_end_value |=> !display_enable_o)
    else $error("display enable past display end");

  chk_emi_pads: assert property (
    $rose(emi_q[lcd_vr_pkg::EMI_RED]) |=> emi_reduction_enable_o)
    else $error("emi reduction not applied");

  chk_vsync_end: assert property (
    line_end && v_cnt_q == vert_sync_start_value |-> ##2 !vsync_o && !frame_pulse_o)
    else $error("frame sync longer than one line");

  chk_mod_clock: assert property (
    !mod_q[lcd_vr_pkg::MOD_SEL] && line_end && !frame_end |=> modulation_o == $past(modulation_o))
    else $error("modulation stepped on a line with frame clock");

  chk_pad_drive: assert property (
    1'b1 |=> pad_drive_6ma_o == $past(emi_q[lcd_vr_pkg::EMI_PAD]))
    else $error("pad drive select not applied");

  chk_de_active: assert property (
    run && h_cnt_q <= horiz_display_end_value && v_cnt_q <= vert_display_end_value |=> display_enable_o)
    else $error("display enable missing in active area");
endmodule

`default_nettype wire

// >>> design/panel_mod_gen.sv
// Purpose: panel modulation signal, toggles every count+1 ticks
// Assumes: tick_i is a one-cycle pulse of the chosen clock
// Notes:   count 0 toggles on every tick

`timescale 1ns/1ps
`default_nettype none

module panel_mod_gen #(
  parameter int CW = 7
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          run_i,
  input  wire logic          tick_i,
  input  wire logic [CW-1:0] count_i,
  output logic               mod_o
);
  logic [CW-1:0] ticks_q;

  // count ticks of the selected clock, flip at the limit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ticks_q <= '0;
      mod_o   <= 1'b0;
    end else if (!run_i) begin
      ticks_q <= '0;
      mod_o   <= 1'b0;
    end else if (tick_i) begin
      if (ticks_q >= count_i) begin
        ticks_q <= '0;
        mod_o   <= !mod_o;
      end else begin
        ticks_q <= ticks_q + 1'b1;
      end
    end
  end

  chk_mod_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && tick_i && ticks_q >= count_i |=> mod_o != $past(mod_o))
    else $error("modulation did not flip at count");
endmodule

`default_nettype wire

// >>> test/panel_model.sv
// Purpose: passive panel that times the sync, enable and modulation lines
// Assumes: syncs active high, one clock domain with the block
// Notes:   reports the last complete interval of each signal in clocks

`timescale 1ns/1ps
`default_nettype none

module panel_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        lsync_i,
  input  wire logic        fsync_i,
  input  wire logic        de_i,
  input  wire logic        mod_i,
  output logic      [15:0] l_per_o,
  output logic      [15:0] l_wid_o,
  output logic      [15:0] f_per_o,
  output logic      [15:0] f_wid_o,
  output logic      [15:0] de_cnt_o,
  output logic      [15:0] m_per_o
);
  logic [15:0] t_q, lr_q, fr_q, mr_q, de_q;
  logic        l_q, f_q, m_q;

  // edge timestamps; a panel only sees edges, so widths come from them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {t_q, lr_q, fr_q, mr_q, de_q, l_q, f_q, m_q} <= '0;
      {l_per_o, l_wid_o, f_per_o, f_wid_o, de_cnt_o, m_per_o} <= '0;
    end else begin
      t_q <= t_q + 16'h0001;
      {l_q, f_q, m_q} <= {lsync_i, fsync_i, mod_i};
      if (lsync_i && !l_q) begin
        l_per_o <= t_q - lr_q;
        lr_q    <= t_q;
      end
      if (!lsync_i && l_q) l_wid_o <= t_q - lr_q;
      if (fsync_i && !f_q) begin
        f_per_o  <= t_q - fr_q;
        fr_q     <= t_q;
        de_cnt_o <= de_q;
        de_q     <= {15'h0000, de_i};
      end else if (de_i) begin
        de_q <= de_q + 16'h0001;
      end
      if (!fsync_i && f_q) f_wid_o <= t_q - fr_q;
      if (mod_i != m_q) begin
        m_per_o <= t_q - mr_q;
        mr_q    <= t_q;
      end
    end
  end
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for lcd_vr_timing
// Assumes: 10 MHz clock, panel_model times the panel lines
// Notes:   short totals keep a line at 32 clocks, a frame at 128

`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed { logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; } row_t;
  typedef struct packed { logic wide; logic dstn; logic [7:0] modv; logic [15:0] wid; logic [15:0] mper; } ph_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] addr  = 16'h0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [7:0]  wd    = 8'h00;
  logic        en    = 1'b0;
  logic [1:0]  ptype = 2'b00;
  logic        wide  = 1'b0;
  logic [7:0]  rdata, v;
  logic        hs, vs, lp, fp, de, sclk, emi, pad, mod;
  logic [15:0] l_per, l_wid, f_per, f_wid, de_cnt, m_per;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          stray     = 0;
  int          edges     = 0;
  // register round trips; reserved bits must read back as zero
  row_t rows [5] = '{'{lcd_vr_pkg::IDX_EMI, 8'hFF, 8'h0F}, '{lcd_vr_pkg::IDX_MOD, 8'hA5, 8'hA5},
                     '{lcd_vr_pkg::IDX_OVF1, 8'hFF, 8'h0F}, '{lcd_vr_pkg::IDX_OVF2, 8'hFF, 8'hFF},
                     '{8'h5B, 8'h77, 8'h00}};
  // minimal legal timing: sync start above display end on both axes
  row_t tim [8] = '{'{lcd_vr_pkg::IDX_OVF1, 8'h00, 8'h00}, '{lcd_vr_pkg::IDX_OVF2, 8'h00, 8'h00},
                    '{lcd_vr_pkg::IDX_HT, 8'h03, 8'h00}, '{lcd_vr_pkg::IDX_HDE, 8'h01, 8'h00},
                    '{lcd_vr_pkg::IDX_HSS, 8'h02, 8'h00}, '{lcd_vr_pkg::IDX_VT, 8'h03, 8'h00},
                    '{lcd_vr_pkg::IDX_VDE, 8'h01, 8'h00}, '{lcd_vr_pkg::IDX_VSS, 8'h02, 8'h00}};
  ph_t  phs [3] = '{'{1'b0, 1'b0, 8'h80, 16'h0008, 16'h0020}, '{1'b1, 1'b1, 8'h81, 16'h0010, 16'h0040},
                    '{1'b0, 1'b0, 8'h00, 16'h0008, 16'h0080}};

  lcd_vr_timing u_lcd_vr_timing (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wd), .io_rdata_o(rdata), .vr_enable_i(en), .panel_type_i(ptype), .hsync_wide_i(wide),
    .hsync_o(hs), .vsync_o(vs), .line_pulse_o(lp), .frame_pulse_o(fp), .display_enable_o(de),
    .panel_shift_clock_o(sclk), .emi_reduction_enable_o(emi), .pad_drive_6ma_o(pad), .modulation_o(mod));

  panel_model u_panel_model (.clk_i(clk_i), .rst_i(rst_i), .lsync_i(hs | lp), .fsync_i(vs | fp), .de_i(de),
    .mod_i(mod), .l_per_o(l_per), .l_wid_o(l_wid), .f_per_o(f_per), .f_wid_o(f_wid), .de_cnt_o(de_cnt),
    .m_per_o(m_per));

  always #50 clk_i = ~clk_i;

  // the unused panel type's pulses must stay silent
  always @(posedge clk_i) begin
    if (ptype == lcd_vr_pkg::PANEL_DSTN ? (hs | vs) : (lp | fp)) stray++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // index write, then data write; strobe drops after the data edge
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    addr <= lcd_vr_pkg::IDX_PORT;
    wd   <= idx;
    wr   <= 1'b1;
    @(posedge clk_i);
    addr <= lcd_vr_pkg::DATA_PORT;
    wd   <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk_i);
    addr <= lcd_vr_pkg::IDX_PORT;
    wd   <= idx;
    wr   <= 1'b1;
    @(posedge clk_i);
    addr <= lcd_vr_pkg::DATA_PORT;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // one panel setup: settle, then time a few frames
  task automatic run_ph(input ph_t p);
    @(posedge clk_i);
    wide  <= p.wide;
    ptype <= p.dstn ? lcd_vr_pkg::PANEL_DSTN : 2'b00;
    reg_wr(lcd_vr_pkg::IDX_MOD, p.modv);
    idle(50);
    #1 stray = 0;
    idle(600);
    chk(l_per, 16'h0020);
    chk(l_wid, p.wid);
    chk(f_per, 16'h0080);
    chk(f_wid, 16'h0020);
    chk(de_cnt, 16'h0020);
    chk(m_per, p.mper);
    chk(stray[15:0], 16'h0000);
  endtask

  initial begin
    #5_000_000;
    n_fail++;
    stop_test();
  end

  initial begin
    idle(8);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({7'h00, hs, vs, lp, fp, de, sclk, emi, pad, mod}, 16'h0000);
    reg_rd(lcd_vr_pkg::IDX_EMI, v);
    chk({8'h00, v}, 16'h0000);
    reg_rd(lcd_vr_pkg::IDX_MOD, v);
    chk({8'h00, v}, 16'h0000);
    foreach (rows[i]) begin
      reg_wr(rows[i].idx, rows[i].wd);
      reg_rd(rows[i].idx, v);
      chk({8'h00, v}, {8'h00, rows[i].rd});
    end
    reg_wr(lcd_vr_pkg::IDX_EMI, 8'h0B);
    idle(2);
    #1 chk({14'h0000, emi, pad}, 16'h0002);
    reg_wr(lcd_vr_pkg::IDX_EMI, 8'h04);
    idle(2);
    #1 chk({14'h0000, emi, pad}, 16'h0001);
    foreach (tim[i]) reg_wr(tim[i].idx, tim[i].wd);
    @(posedge clk_i);
    en <= 1'b1;
    foreach (phs[i]) run_ph(phs[i]);
    // ninth bits: total 0x103, display end 0x101, sync start 0x102
    reg_wr(lcd_vr_pkg::IDX_OVF1, 8'h01);
    reg_wr(lcd_vr_pkg::IDX_OVF2, 8'h03);
    idle(20000);
    chk(l_per, 16'h0820);
    chk(l_wid, 16'h0008);
    chk(de_cnt, 16'h1020);
    chk(f_per, 16'h2080);
    @(posedge clk_i);
    en <= 1'b0;
    idle(3);
    #1 chk({11'h000, hs, vs, de, sclk, mod}, 16'h0000);
    // shift clock first rise after enable: two register stages plus the delay taps
    for (int k = 0; k < 4; k++) begin
      reg_wr(lcd_vr_pkg::IDX_EMI, 8'(k));
      @(posedge clk_i);
      en    <= 1'b1;
      edges = 0;
      do begin
        @(posedge clk_i);
        edges++;
        #1;
      end while (!sclk && edges < 8);
      chk(16'(edges), 16'(3 + k));
      @(posedge clk_i);
      #1 chk({15'h0000, sclk}, 16'h0000);
      @(posedge clk_i);
      en <= 1'b0;
      idle(6);
    end
    // second reset mid-run: control registers back to 00h, outputs quiet
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({7'h00, hs, vs, lp, fp, de, sclk, emi, pad, mod}, 16'h0000);
    reg_rd(lcd_vr_pkg::IDX_EMI, v);
    chk({8'h00, v}, 16'h0000);
    stop_test();
  end
endmodule

`default_nettype wire
